// >>> design/rsa_amp_keying.sv
// Amplitude scale factor selection and automatic keying ramp
`timescale 1ns/1ns
module rsa_amp_keying (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        amp_ctrl_enable,
	input  wire logic        auto_keying_enable,
	input  wire logic        manual_keying_enable,
	input  wire logic        keying_level,
	input  wire logic [31:0] amp_word,
	output logic      [13:0] amplitude_scale_value
);
	import rsa_pkg::*;

	logic [15:0] rate_cnt_r, rate_cnt_nxt;
	logic [13:0] ramp_r, ramp_nxt, amp_nxt;

	wire [13:0] ceiling   = amp_word[RSA_AMP_SCALE_HI:RSA_AMP_SCALE_LO];
	wire [15:0] ramp_rate = amp_word[RSA_AMP_RATE_HI:RSA_AMP_RATE_LO];
	wire [13:0] step      = 14'h0001 << amp_word[RSA_AMP_STEP_HI:RSA_AMP_STEP_LO];
	wire        tick      = rate_cnt_r >= ramp_rate;
	wire [14:0] up_sum    = {1'b0, ramp_r} + {1'b0, step};
	wire [13:0] up_val    = (up_sum > {1'b0, ceiling}) ? ceiling : up_sum[13:0];
	wire [13:0] dn_val    = (ramp_r < step) ? 14'h0000 : ramp_r - step;

	assign rate_cnt_nxt = (!auto_keying_enable || tick) ? 16'h0000 : rate_cnt_r + 16'h0001;

	always_comb begin
		if (!auto_keying_enable)
			ramp_nxt = 14'h0000;
		else if (ramp_r > ceiling)
			ramp_nxt = ceiling;
		else if (tick)
			ramp_nxt = keying_level ? up_val : dn_val;
		else
			ramp_nxt = ramp_r;
	end

	always_comb begin
		if (!amp_ctrl_enable)
			amp_nxt = RSA_AMP_FULL_SCALE;
		else if (auto_keying_enable)
			amp_nxt = ramp_nxt;
		else if (manual_keying_enable)
			amp_nxt = keying_level ? ceiling : 14'h0000;
		else
			amp_nxt = ceiling;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rate_cnt_r            <= 16'h0000;
			ramp_r                <= 14'h0000;
			amplitude_scale_value <= RSA_AMP_FULL_SCALE;
		end else begin
			rate_cnt_r            <= rate_cnt_nxt;
			ramp_r                <= ramp_nxt;
			amplitude_scale_value <= amp_nxt;
		end
	end

endmodule // rsa_amp_keying

// >>> design/rsa_pkg.sv
// Shared constants and types for the RAM segment, amplitude and sync register group
package rsa_pkg;

	// ==========================================================
	// Serial port addresses and framing
	localparam logic [4:0] RSA_ADDR_SEG_A   = 5'h05;
	localparam logic [4:0] RSA_ADDR_SEG_B   = 5'h06;
	localparam logic [4:0] RSA_ADDR_AMP     = 5'h09;
	localparam logic [4:0] RSA_ADDR_SYNC    = 5'h0A;
	localparam int         RSA_INSTR_BITS   = 8;
	localparam int         RSA_INSTR_RD_BIT = 7;
	localparam logic [5:0] RSA_SEG_LEN      = 6'h30;
	localparam logic [5:0] RSA_WORD_LEN     = 6'h20;

	// ==========================================================
	// Segment register fields
	localparam int RSA_SEG_RATE_HI  = 47;
	localparam int RSA_SEG_RATE_LO  = 32;
	localparam int RSA_SEG_END_HI   = 31;
	localparam int RSA_SEG_END_LO   = 22;
	localparam int RSA_SEG_START_HI = 15;
	localparam int RSA_SEG_START_LO = 6;
	localparam int RSA_SEG_MODE_HI  = 2;
	localparam int RSA_SEG_MODE_LO  = 0;
	localparam logic [47:0] RSA_SEG_MASK = 48'hFFFF_FFC0_FFC7;
	localparam logic [47:0] RSA_SEG_RST  = 48'h0000_0000_0000;

	// ==========================================================
	// Amplitude register fields
	localparam int RSA_AMP_RATE_HI  = 31;
	localparam int RSA_AMP_RATE_LO  = 16;
	localparam int RSA_AMP_SCALE_HI = 15;
	localparam int RSA_AMP_SCALE_LO = 2;
	localparam int RSA_AMP_STEP_HI  = 1;
	localparam int RSA_AMP_STEP_LO  = 0;
	localparam logic [31:0] RSA_AMP_MASK       = 32'hFFFF_FFFF;
	localparam logic [31:0] RSA_AMP_RST        = 32'h0000_0000;
	localparam logic [13:0] RSA_AMP_FULL_SCALE = 14'h3FFF;

	// ==========================================================
	// Sync register fields
	localparam int RSA_SYNC_VDLY_HI   = 31;
	localparam int RSA_SYNC_VDLY_LO   = 28;
	localparam int RSA_SYNC_RX_EN     = 27;
	localparam int RSA_SYNC_GEN_EN    = 26;
	localparam int RSA_SYNC_GEN_POL   = 25;
	localparam int RSA_SYNC_PRESET_HI = 23;
	localparam int RSA_SYNC_PRESET_LO = 18;
	localparam int RSA_SYNC_GDLY_HI   = 15;
	localparam int RSA_SYNC_GDLY_LO   = 11;
	localparam int RSA_SYNC_RDLY_HI   = 7;
	localparam int RSA_SYNC_RDLY_LO   = 3;
	localparam int RSA_SYNC_STEP_PS   = 75;
	localparam logic [31:0] RSA_SYNC_MASK = 32'hFEFC_F8F8;
	localparam logic [31:0] RSA_SYNC_RST  = 32'h0000_0000;

	// ==========================================================
	// Types
	typedef struct packed {
		logic sclk;
		logic cs_b;
		logic sdio;
		logic ram_trigger_pin;
		logic amplitude_keying;
		logic sync_in;
		logic violation;
	} rsa_pins_s;

	typedef struct packed {
		logic [15:0] step_rate;
		logic [9:0]  end_addr;
		logic [9:0]  start_addr;
		logic [2:0]  mode;
	} rsa_seg_s;

	typedef enum logic [1:0] {
		RSA_SP_IDLE  = 2'b00,
		RSA_SP_INSTR = 2'b01,
		RSA_SP_DATA  = 2'b11,
		RSA_SP_DONE  = 2'b10
	} rsa_sp_state_e;

endpackage

// >>> design/rsa_regs.sv
// Serial-port register group: RAM segments, amplitude scale and multichip sync
`timescale 1ns/1ns
module rsa_regs (
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	input  wire logic              sclk,
	input  wire logic              cs_b,
	input  wire logic              sdio_in,
	output logic                   sdio_out,
	output logic                   sdio_oe,
	input  wire logic              ram_trigger_pin,
	input  wire logic              amplitude_keying,
	input  wire logic              sync_in,
	input  wire logic              sync_violation_in,
	input  wire logic              ram_enable,
	input  wire logic              amp_ctrl_enable,
	input  wire logic              auto_keying_enable,
	input  wire logic              manual_keying_enable,
	input  wire logic              sync_validation_disable,
	output rsa_pkg::rsa_seg_s      seg_active,
	output logic                   seg_b_selected,
	output logic      [13:0]       amplitude_scale_value,
	output logic      [3:0]        sync_valid_delay,
	output logic                   sync_rx_enable,
	output logic                   sync_gen_enable,
	output logic                   sync_gen_falling,
	output logic      [4:0]        sync_gen_delay,
	output logic      [4:0]        sync_rx_delay,
	output logic      [5:0]        sync_gen_state,
	output logic                   sync_clk_out,
	output logic                   sync_timing_error_out
);
	import rsa_pkg::*;

	// ==========================================================
	// Helper functions
	function automatic rsa_seg_s seg_fields(input logic [47:0] w);
		rsa_seg_s s;
		s.step_rate  = w[RSA_SEG_RATE_HI:RSA_SEG_RATE_LO];
		s.end_addr   = w[RSA_SEG_END_HI:RSA_SEG_END_LO];
		s.start_addr = w[RSA_SEG_START_HI:RSA_SEG_START_LO];
		s.mode       = w[RSA_SEG_MODE_HI:RSA_SEG_MODE_LO];
		return s;
	endfunction

	function automatic logic [5:0] frame_len(input logic [4:0] a);
		return (a == RSA_ADDR_SEG_A || a == RSA_ADDR_SEG_B) ? RSA_SEG_LEN : RSA_WORD_LEN;
	endfunction

	// ==========================================================
	// Pin synchronisers
	rsa_pins_s pins_raw;
	rsa_pins_s pin_meta_r;
	rsa_pins_s pin_sync_r;
	rsa_pins_s pin_prev_r;

	assign pins_raw.sclk             = sclk;
	assign pins_raw.cs_b             = cs_b;
	assign pins_raw.sdio             = sdio_in;
	assign pins_raw.ram_trigger_pin  = ram_trigger_pin;
	assign pins_raw.amplitude_keying = amplitude_keying;
	assign pins_raw.sync_in          = sync_in;
	assign pins_raw.violation        = sync_violation_in;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			// Chip select resets to its idle level, so no false frame start
			pin_meta_r <= '{cs_b: 1'b1, default: 1'b0};
			pin_sync_r <= '{cs_b: 1'b1, default: 1'b0};
			pin_prev_r <= '{cs_b: 1'b1, default: 1'b0};
		end else begin
			pin_meta_r <= pins_raw;
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	wire sclk_rise = pin_sync_r.sclk & ~pin_prev_r.sclk;
	wire cs_active = ~pin_sync_r.cs_b;
	wire rt_rise   = pin_sync_r.ram_trigger_pin & ~pin_prev_r.ram_trigger_pin;
	wire rt_fall   = ~pin_sync_r.ram_trigger_pin & pin_prev_r.ram_trigger_pin;
	wire sdio_bit  = pin_sync_r.sdio;

	// ==========================================================
	// Register storage
	logic [47:0] seg_a_r;
	logic [47:0] seg_b_r;
	logic [31:0] amp_r;
	logic [31:0] sync_r;

	// ==========================================================
	// Serial port state machine
	rsa_sp_state_e sp_state_r, sp_state_nxt;
	logic [5:0]  bit_cnt_r, bit_cnt_nxt;
	logic [47:0] sh_r, sh_nxt;
	logic [4:0]  addr_r, addr_nxt;
	logic        rd_r, rd_nxt;
	logic [5:0]  len_r, len_nxt;
	logic        wr_stb;
	logic [47:0] wr_data;

	wire [47:0] sh_in      = {sh_r[46:0], sdio_bit};
	wire [4:0]  instr_addr = sh_in[4:0];
	wire        instr_rd   = sh_in[RSA_INSTR_RD_BIT];
	wire        instr_last = bit_cnt_r == 6'(RSA_INSTR_BITS - 1);
	wire        data_last  = bit_cnt_r == len_r - 6'h01;

	logic [47:0] rd_word;
	always_comb begin
		case (instr_addr)
			RSA_ADDR_SEG_A: rd_word = seg_a_r;
			RSA_ADDR_SEG_B: rd_word = seg_b_r;
			RSA_ADDR_AMP:   rd_word = {amp_r, 16'h0000};
			RSA_ADDR_SYNC:  rd_word = {sync_r, 16'h0000};
			default:        rd_word = 48'h0000_0000_0000;
		endcase
	end

	always_comb begin
		sp_state_nxt = sp_state_r;
		bit_cnt_nxt  = bit_cnt_r;
		sh_nxt       = sh_r;
		addr_nxt     = addr_r;
		rd_nxt       = rd_r;
		len_nxt      = len_r;
		wr_stb       = 1'b0;
		wr_data      = sh_in;
		if (!cs_active) begin
			sp_state_nxt = RSA_SP_IDLE;
			bit_cnt_nxt  = 6'h00;
			sh_nxt       = 48'h0000_0000_0000;
			rd_nxt       = 1'b0;
		end else begin
			case (sp_state_r)
				RSA_SP_IDLE: begin
					sp_state_nxt = RSA_SP_INSTR;
					bit_cnt_nxt  = 6'h00;
				end
				RSA_SP_INSTR: begin
					if (sclk_rise) begin
						sh_nxt      = sh_in;
						bit_cnt_nxt = bit_cnt_r + 6'h01;
						if (instr_last) begin
							sp_state_nxt = RSA_SP_DATA;
							bit_cnt_nxt  = 6'h00;
							addr_nxt     = instr_addr;
							rd_nxt       = instr_rd;
							len_nxt      = frame_len(instr_addr);
							sh_nxt       = instr_rd ? rd_word : 48'h0000_0000_0000;
						end
					end
				end
				RSA_SP_DATA: begin
					if (sclk_rise) begin
						sh_nxt      = rd_r ? {sh_r[46:0], 1'b0} : sh_in;
						bit_cnt_nxt = bit_cnt_r + 6'h01;
						if (data_last) begin
							sp_state_nxt = RSA_SP_DONE;
							wr_stb       = ~rd_r;
						end
					end
				end
				RSA_SP_DONE: begin
					sp_state_nxt = RSA_SP_DONE;
				end
				default: begin
					sp_state_nxt = RSA_SP_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sp_state_r <= RSA_SP_IDLE;
			bit_cnt_r  <= 6'h00;
			sh_r       <= 48'h0000_0000_0000;
			addr_r     <= 5'h00;
			rd_r       <= 1'b0;
			len_r      <= RSA_WORD_LEN;
		end else begin
			sp_state_r <= sp_state_nxt;
			bit_cnt_r  <= bit_cnt_nxt;
			sh_r       <= sh_nxt;
			addr_r     <= addr_nxt;
			rd_r       <= rd_nxt;
			len_r      <= len_nxt;
		end
	end

	// Read data leaves MSB first; the pin is driven only during a read data phase
	wire sdio_oe_nxt = (sp_state_nxt == RSA_SP_DATA) & rd_nxt;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sdio_out <= 1'b0;
			sdio_oe  <= 1'b0;
		end else begin
			sdio_out <= sdio_oe_nxt & sh_nxt[47];
			sdio_oe  <= sdio_oe_nxt;
		end
	end

	// ==========================================================
	// Register writes
	wire wr_seg_a = wr_stb && addr_r == RSA_ADDR_SEG_A;
	wire wr_seg_b = wr_stb && addr_r == RSA_ADDR_SEG_B;
	wire wr_amp   = wr_stb && addr_r == RSA_ADDR_AMP;
	wire wr_sync  = wr_stb && addr_r == RSA_ADDR_SYNC;

	wire [47:0] seg_a_nxt = wr_seg_a ? (wr_data & RSA_SEG_MASK) : seg_a_r;
	wire [47:0] seg_b_nxt = wr_seg_b ? (wr_data & RSA_SEG_MASK) : seg_b_r;
	wire [31:0] amp_nxt   = wr_amp ? (wr_data[31:0] & RSA_AMP_MASK) : amp_r;
	wire [31:0] sync_nxt  = wr_sync ? (wr_data[31:0] & RSA_SYNC_MASK) : sync_r;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			seg_a_r <= RSA_SEG_RST;
			seg_b_r <= RSA_SEG_RST;
			amp_r   <= RSA_AMP_RST;
			sync_r  <= RSA_SYNC_RST;
		end else begin
			seg_a_r <= seg_a_nxt;
			seg_b_r <= seg_b_nxt;
			amp_r   <= amp_nxt;
			sync_r  <= sync_nxt;
		end
	end

	// ==========================================================
	// RAM segment selection by trigger edges
	logic seg_b_sel_nxt;

	always_comb begin
		if (ram_enable && rt_fall)
			seg_b_sel_nxt = 1'b1;
		else if (ram_enable && rt_rise)
			seg_b_sel_nxt = 1'b0;
		else
			seg_b_sel_nxt = seg_b_selected;
	end

	// Active copy follows writes to the selected segment without extra update
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			seg_b_selected <= 1'b0;
			seg_active     <= '0;
		end else begin
			seg_b_selected <= seg_b_sel_nxt;
			seg_active     <= seg_b_sel_nxt ? seg_fields(seg_b_nxt) : seg_fields(seg_a_nxt);
		end
	end

	// ==========================================================
	// Sync configuration fields
	assign sync_valid_delay = sync_r[RSA_SYNC_VDLY_HI:RSA_SYNC_VDLY_LO];
	assign sync_rx_enable   = sync_r[RSA_SYNC_RX_EN];
	assign sync_gen_enable  = sync_r[RSA_SYNC_GEN_EN];
	assign sync_gen_falling = sync_r[RSA_SYNC_GEN_POL];
	assign sync_gen_delay   = sync_r[RSA_SYNC_GDLY_HI:RSA_SYNC_GDLY_LO];
	assign sync_rx_delay    = sync_r[RSA_SYNC_RDLY_HI:RSA_SYNC_RDLY_LO];

	// ==========================================================
	// Sub-blocks
	rsa_amp_keying u_amp (
		.ref_clk               (ref_clk),
		.rst_b                 (rst_b),
		.amp_ctrl_enable       (amp_ctrl_enable),
		.auto_keying_enable    (auto_keying_enable),
		.manual_keying_enable  (manual_keying_enable),
		.keying_level          (pin_sync_r.amplitude_keying),
		.amp_word              (amp_r),
		.amplitude_scale_value (amplitude_scale_value)
	);

	rsa_sync_ctrl u_sync (
		.ref_clk               (ref_clk),
		.rst_b                 (rst_b),
		.sync_word             (sync_r),
		.sync_level            (pin_sync_r.sync_in),
		.violation             (pin_sync_r.violation),
		.validation_disable    (sync_validation_disable),
		.gen_state             (sync_gen_state),
		.sync_clk_out          (sync_clk_out),
		.sync_timing_error_out (sync_timing_error_out)
	);

endmodule // rsa_regs

// >>> design/rsa_sync_ctrl.sv
// Multichip sync clock generator state and timing error latch
`timescale 1ns/1ns
module rsa_sync_ctrl (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic [31:0] sync_word,
	input  wire logic        sync_level,
	input  wire logic        violation,
	input  wire logic        validation_disable,
	output logic      [5:0]  gen_state,
	output logic             sync_clk_out,
	output logic             sync_timing_error_out
);
	import rsa_pkg::*;

	logic sync_prev_r;
	logic [5:0] state_nxt;
	logic       err_nxt;

	wire rx_en     = sync_word[RSA_SYNC_RX_EN];
	wire gen_en    = sync_word[RSA_SYNC_GEN_EN];
	wire sync_rise = sync_level & ~sync_prev_r;

	assign state_nxt = (rx_en && sync_rise) ?
		sync_word[RSA_SYNC_PRESET_HI:RSA_SYNC_PRESET_LO] : gen_state + 6'h01;

	always_comb begin
		if (validation_disable)
			err_nxt = 1'b0;
		else if (rx_en && violation)
			err_nxt = 1'b1;
		else
			err_nxt = sync_timing_error_out;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync_prev_r           <= 1'b0;
			gen_state             <= 6'h00;
			sync_clk_out          <= 1'b0;
			sync_timing_error_out <= 1'b0;
		end else begin
			sync_prev_r           <= sync_level;
			gen_state             <= state_nxt;
			sync_clk_out          <= gen_en & ~state_nxt[5];
			sync_timing_error_out <= err_nxt;
		end
	end

endmodule // rsa_sync_ctrl

// >>> verif/rsa_host_model.sv
// Host controller model driving the serial configuration port
`timescale 1ns/1ns
module rsa_host_model (
	input  wire logic ref_clk,
	input  wire logic sdio_wire,
	output logic      sclk,
	output logic      cs_b,
	output wire       sdio_drv
);
	import rsa_pkg::*;
	logic rel_r;
	logic bit_r;
	logic tog_r;
	initial begin
		sclk = 1'b0;
		cs_b = 1'b1;
		rel_r = 1'b1;
		bit_r = 1'b0;
		tog_r = 1'b0;
	end
	// Released line toggles so stale data never looks valid
	always @(posedge ref_clk) tog_r <= ~tog_r;
	assign sdio_drv = rel_r ? tog_r : bit_r;
	// ==========================================================
	// One whole frame: instruction byte, then the register's bit count
	task automatic xfer(input logic [7:0] ins, input logic [47:0] wd, output logic [47:0] rdat);
		int n;
		logic [55:0] sh;
		n = (ins[4:0] == RSA_ADDR_SEG_A || ins[4:0] == RSA_ADDR_SEG_B) ? 48 : 32;
		sh = (n == 48) ? {ins, wd} : {ins, wd[31:0], 16'h0000};
		rdat = '0;
		@(posedge ref_clk);
		cs_b <= 1'b0;
		rel_r <= 1'b0;
		for (int i = 0; i < 8 + n; i++) begin
			@(posedge ref_clk);
			bit_r <= sh[55-i];
			repeat (6) @(posedge ref_clk);
			sclk <= 1'b1;
			if (i >= 8) rdat = {rdat[46:0], sdio_wire};
			@(posedge ref_clk);
			// Last instruction bit held one edge past the rise
			if (ins[7] && i == 7) rel_r <= 1'b1;
			repeat (5) @(posedge ref_clk);
			sclk <= 1'b0;
		end
		repeat (6) @(posedge ref_clk);
		cs_b <= 1'b1;
		rel_r <= 1'b1;
		repeat (8) @(posedge ref_clk);
	endtask
endmodule // rsa_host_model

// >>> verif/rsa_regs_asserts.sv
// Port checker for the RAM segment, amplitude and sync register group
`timescale 1ns/1ns
module rsa_regs_chk (
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic        ram_trigger_pin,
	input wire logic        amplitude_keying,
	input wire logic        ram_enable,
	input wire logic        amp_ctrl_enable,
	input wire logic        auto_keying_enable,
	input wire logic        manual_keying_enable,
	input wire logic        sync_validation_disable,
	input wire logic        seg_b_selected,
	input wire logic [13:0] amplitude_scale_value,
	input wire logic        sync_rx_enable,
	input wire logic        sync_gen_enable,
	input wire logic [5:0]  sync_gen_state,
	input wire logic        sync_clk_out,
	input wire logic        sync_timing_error_out
);
	import rsa_pkg::*;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	wire man_only = amp_ctrl_enable & ~auto_keying_enable & manual_keying_enable;
	wire err      = sync_timing_error_out;
	// ==========================================================
	// Assertions
	AST_AMP_OFF: assert property (!amp_ctrl_enable ##1 !amp_ctrl_enable
		|-> amplitude_scale_value == 14'h3FFF) else $error("scale not full with control off");
	AST_MAN_LOW: assert property ((man_only && !amplitude_keying)[*5]
		|-> amplitude_scale_value == 14'h0000) else $error("scale not zero with key low");
	AST_ERR_CLR: assert property (sync_validation_disable |=> !err)
		else $error("sync error not cleared");
	AST_ERR_HOLD: assert property (err && !sync_validation_disable |=> err)
		else $error("sync error not held");
	AST_ERR_SET: assert property ($rose(err) |-> !$past(sync_validation_disable))
		else $error("sync error set while validation off");
	AST_SEG_B: assert property ($rose(seg_b_selected) |-> !$past(ram_trigger_pin))
		else $error("second segment chosen without falling trigger");
	AST_SEG_A: assert property ($fell(seg_b_selected) |-> $past(ram_trigger_pin))
		else $error("first segment chosen without rising trigger");
	AST_SEG_HOLD: assert property ((!ram_enable)[*5] |-> $stable(seg_b_selected))
		else $error("segment changed with RAM disabled");
	AST_GEN_INC: assert property (!sync_rx_enable ##1 !sync_rx_enable
		|=> sync_gen_state == $past(sync_gen_state) + 6'h01) else $error("state not counting");
	AST_GEN_OFF: assert property (!sync_gen_enable ##1 !sync_gen_enable
		|-> !sync_clk_out) else $error("sync clock with generator off");
	// ==========================================================
	// Coverage
	COV_SEG_B: cover property ($rose(seg_b_selected));
	COV_ERR: cover property ($rose(err));
	COV_MAN: cover property (man_only && amplitude_scale_value != 14'h0000);
endmodule // rsa_regs_chk

bind rsa_regs rsa_regs_chk u_chk (
	.ref_clk(ref_clk), .rst_b(rst_b), .ram_trigger_pin(ram_trigger_pin),
	.amplitude_keying(amplitude_keying), .ram_enable(ram_enable),
	.amp_ctrl_enable(amp_ctrl_enable), .auto_keying_enable(auto_keying_enable),
	.manual_keying_enable(manual_keying_enable),
	.sync_validation_disable(sync_validation_disable), .seg_b_selected(seg_b_selected),
	.amplitude_scale_value(amplitude_scale_value), .sync_rx_enable(sync_rx_enable),
	.sync_gen_enable(sync_gen_enable), .sync_gen_state(sync_gen_state),
	.sync_clk_out(sync_clk_out), .sync_timing_error_out(sync_timing_error_out)
);

// >>> verif/tb_ram_segment_amplitude_sync_regs.sv
// Testbench for the RAM segment, amplitude and sync register group
`timescale 1ns/1ns
module tb_ram_segment_amplitude_sync_regs;
	import rsa_pkg::*;
	logic              ref_clk = 1'b0;
	logic              rst_b = 1'b0;
	rsa_pins_s         pins;
	logic              ram_en, amp_en, auto_en, man_en, val_dis;
	wire               sclk, cs_b, host_sdio, sdio_out, sdio_oe;
	wire               sdio_wire = sdio_oe ? sdio_out : host_sdio;
	rsa_seg_s          seg;
	logic              seg_b, rx_en, gen_en, gen_fall, sclk_o, err;
	logic       [13:0] amp, c, prev;
	logic       [3:0]  vdly;
	logic       [4:0]  gdly, rdly;
	logic       [5:0]  gst;
	logic       [5:0]  p [2];
	logic       [5:0]  st [2];
	logic       [47:0] rd, d, sa, sb;
	logic       [4:0]  al [5] = '{5'h05, 5'h06, 5'h09, 5'h0A, 5'h07};
	int                n_mismatch, checks, r, s, nch, ti;

	always #10 ref_clk = ~ref_clk;

	rsa_host_model u_host (.ref_clk(ref_clk), .sdio_wire(sdio_wire), .sclk(sclk),
		.cs_b(cs_b), .sdio_drv(host_sdio));
	rsa_regs u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
		.sdio_in(sdio_wire), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.ram_trigger_pin(pins.ram_trigger_pin), .amplitude_keying(pins.amplitude_keying),
		.sync_in(pins.sync_in), .sync_violation_in(pins.violation), .ram_enable(ram_en),
		.amp_ctrl_enable(amp_en), .auto_keying_enable(auto_en),
		.manual_keying_enable(man_en), .sync_validation_disable(val_dis),
		.seg_active(seg), .seg_b_selected(seg_b), .amplitude_scale_value(amp),
		.sync_valid_delay(vdly), .sync_rx_enable(rx_en), .sync_gen_enable(gen_en),
		.sync_gen_falling(gen_fall), .sync_gen_delay(gdly), .sync_rx_delay(rdly),
		.sync_gen_state(gst), .sync_clk_out(sclk_o), .sync_timing_error_out(err));

	// ==========================================================
	// Helpers
	function automatic logic [47:0] msk(logic [4:0] a);
		case (a)
			RSA_ADDR_SEG_A, RSA_ADDR_SEG_B: return RSA_SEG_MASK;
			RSA_ADDR_AMP:                   return {16'h0000, RSA_AMP_MASK};
			RSA_ADDR_SYNC:                  return {16'h0000, RSA_SYNC_MASK};
			default:                        return 48'h0000_0000_0000;
		endcase
	endfunction
	function automatic rsa_seg_s sx(logic [47:0] v);
		return {v[47:22], v[15:6], v[2:0]};
	endfunction
	task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic complete_run;
		$display("checks=%0d mismatches=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		cyc(100000);
		n_mismatch++;
		complete_run();
	end

	// ==========================================================
	// Main sequence
	initial begin
		pins = '0;
		{ram_en, amp_en, auto_en, man_en, val_dis} = 5'b00001;
		n_mismatch = 0;
		checks = 0;
		void'($urandom(32'h73325465));
		cyc(16);
		rst_b <= 1'b1;
		cyc(4);
		chk(amp, 14'h3FFF, "reset scale");
		chk({vdly, rx_en, gen_en, gen_fall, gdly, rdly}, 0, "reset sync");
		foreach (al[i]) begin
			u_host.xfer({3'b100, al[i]}, 0, rd);
			chk(rd, 0, "reset readback");
		end
		for (int k = 0; k < 3; k++) foreach (al[i]) begin
			d = {16'($urandom), $urandom};
			u_host.xfer({3'b000, al[i]}, d, rd);
			u_host.xfer({3'b100, al[i]}, 0, rd);
			chk(rd, d & msk(al[i]), "readback");
			if (al[i] == RSA_ADDR_SYNC) chk({vdly, rx_en, gen_en, gen_fall, gdly, rdly},
				{d[31:25], d[15:11], d[7:3]}, "sync fields");
		end
		sa = {16'($urandom), $urandom};
		sb = {16'($urandom), $urandom};
		u_host.xfer({3'b000, RSA_ADDR_SEG_A}, sa, rd);
		u_host.xfer({3'b000, RSA_ADDR_SEG_B}, sb, rd);
		ram_en <= 1'b1;
		cyc(2);
		pins.ram_trigger_pin <= 1'b1;
		cyc(8);
		chk({seg_b, seg}, {1'b0, sx(sa)}, "rising trigger");
		pins.ram_trigger_pin <= 1'b0;
		cyc(8);
		chk({seg_b, seg}, {1'b1, sx(sb)}, "falling trigger");
		ram_en <= 1'b0;
		cyc(8);
		pins.ram_trigger_pin <= 1'b1;
		cyc(8);
		chk(seg_b, 1, "trigger with RAM off");
		sb = {16'($urandom), $urandom};
		u_host.xfer({3'b000, RSA_ADDR_SEG_B}, sb, rd);
		chk(seg, sx(sb), "selected segment rewrite");
		d = {16'($urandom), $urandom};
		u_host.xfer({3'b000, RSA_ADDR_AMP}, d, rd);
		cyc(3);
		chk(amp, 14'h3FFF, "scale with control off");
		amp_en <= 1'b1;
		cyc(3);
		chk(amp, d[15:2], "direct scale");
		man_en <= 1'b1;
		pins.amplitude_keying <= 1'b1;
		cyc(6);
		chk(amp, d[15:2], "manual key high");
		pins.amplitude_keying <= 1'b0;
		cyc(6);
		chk(amp, 0, "manual key low");
		r = $urandom % 4;
		s = $urandom % 4;
		c = 14'h0040 + 14'($urandom % 64);
		u_host.xfer({3'b000, RSA_ADDR_AMP}, {16'(r), c, 2'(s)}, rd);
		man_en <= 1'b0;
		auto_en <= 1'b1;
		pins.amplitude_keying <= 1'b1;
		prev = amp;
		nch = 0;
		for (int i = 0; i < 2000 && amp !== c; i++) begin
			@(posedge ref_clk);
			#1;
			if (amp > c) chk(amp, c, "ramp above ceiling");
			if (amp !== prev) begin
				nch++;
				if (nch == 1) chk(amp, 14'h0001 << s, "first ramp step");
				if (nch == 2) chk(i - ti, r + 1, "ramp rate");
				ti = i;
				prev = amp;
			end
		end
		chk(amp, c, "ramp ceiling");
		u_host.xfer({3'b000, RSA_ADDR_SYNC}, 48'h0800_0000, rd);
		val_dis <= 1'b0;
		cyc(2);
		pins.violation <= 1'b1;
		cyc(6);
		pins.violation <= 1'b0;
		cyc(6);
		chk(err, 1, "error latched");
		val_dis <= 1'b1;
		cyc(3);
		chk(err, 0, "error cleared");
		for (int j = 0; j < 2; j++) begin
			p[j] = 6'($urandom);
			u_host.xfer({3'b000, RSA_ADDR_SYNC}, {16'h0000, 8'h08, p[j], 18'h00000}, rd);
			cyc(j * 5);
			pins.sync_in <= 1'b1;
			cyc(12);
			st[j] = gst;
			pins.sync_in <= 1'b0;
		end
		chk(6'(st[1] - st[0]), 6'(p[1] - p[0]), "preset load");
		complete_run();
	end
endmodule // tb_ram_segment_amplitude_sync_regs
